// *** rtl/smf_pkg.sv ***
`default_nettype none
package smf_pkg;
  // ----------------------------------------
  // operating modes, mode field encoding
  // ----------------------------------------
  typedef enum logic [2:0] {
    SMF_INIT      = 3'b000,
    SMF_NORMAL    = 3'b001,
    SMF_STOP      = 3'b010,
    SMF_SLEEP     = 3'b011,
    SMF_RESTART   = 3'b100,
    SMF_FAIL_SAFE = 3'b101
  } smf_mode_t;

  // mode field values software may request, and the field reset value
  localparam logic [2:0] SMF_REQ_NORMAL = 3'h1;
  localparam logic [2:0] SMF_REQ_STOP   = 3'h2;
  localparam logic [2:0] SMF_REQ_SLEEP  = 3'h3;
  localparam logic [2:0] SMF_REQ_RESET  = 3'h4;
  localparam logic [2:0] SMF_FIELD_RST  = 3'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SMF_CLK_MHZ         = 50;
  localparam int SMF_RD_US           = 10;
  localparam int SMF_LW_MS           = 200;
  localparam int SMF_CFG_F_US        = 2;
  localparam int SMF_RD_CYC          = SMF_RD_US * SMF_CLK_MHZ;
  localparam int SMF_LW_CYC          = SMF_LW_MS * 1000 * SMF_CLK_MHZ;
  localparam int SMF_CFG_F_CYC       = SMF_CFG_F_US * SMF_CLK_MHZ;

  // ----------------------------------------
  // grouped status
  // ----------------------------------------
  typedef struct packed {
    logic       config_pin_level;
    logic       failure_count_select;
    logic       overvoltage_flag;
    logic       power_on_reset_flag;
    logic       development_mode;
    logic [1:0] wd_fail_count;
  } smf_status_t;

  localparam smf_status_t SMF_STATUS_RST = '0;
endpackage : smf_pkg
`default_nettype wire

// *** rtl/smf_mode_fail_config.sv ***
// Operation
// - six modes; init entered at power-up and on soft reset
// - stop keeps main regulator on, sleep switches it off
// - restart after wake in sleep/fail-safe or failure; hold reset low
// - leave restart to normal after reset delay once failure gone
// - fail-safe after critical failure, regulator off, until wake or temp ok
// - development mode stops watchdog counter, no trigger needed
// - test pin low during init selects development mode
// - mode requested through the mode field of the 16-bit SPI link
// - mode field cleared passing through restart, set to the new mode on leaving normal or entering normal/stop
// - power-on starts init with watchdog long open window
// - weak pull-down on interrupt pin during reset delay while power-on flag set
// - filter interrupt pin, latch level on reset output rising edge
// - while power-on flag set, re-sample on every reset cycle
// - unstable interrupt pin level latches zero
// - pull-up reads config level one, none reads zero
// - level one: watchdog failure restarts; fail output 1st or 2nd
// - level zero: fail-safe; config 4 first failure restarts only
// - overvoltage with enable: flag, fail output, restart or fail-safe
// - configuration readable via count select and config level bits
// - overvoltage without enable sets flag only
// - any SPI command in init moves to normal
// - no trigger in long open window is a watchdog failure, restart or fail-safe
// - latched configuration kept until power-on reset
`default_nettype none
module smf_mode_fail_config #(
  parameter int RD_CYC  = smf_pkg::SMF_RD_CYC,
  parameter int LW_CYC  = smf_pkg::SMF_LW_CYC,
  parameter int CFG_CYC = smf_pkg::SMF_CFG_F_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               spi_cmd_valid,
  input  wire logic               spi_mode_write,
  input  wire logic [2:0]         spi_mode_value,
  input  wire logic               wd_trigger,
  input  wire logic               wd_fail_event,
  input  wire logic               undervoltage,
  input  wire logic               overvoltage,
  input  wire logic               overtemp,
  input  wire logic               wake_event,
  input  wire logic               overvoltage_reset_enable,
  input  wire logic               failure_count_select,
  input  wire logic               power_on_flag_clear,
  input  wire logic               test_pin,
  input  wire logic               interrupt_pin_in,
  output logic                    interrupt_pin_pd_oe_n,
  output logic                    reset_output,
  output logic                    fail_output,
  output logic                    main_regulator_en,
  output logic [2:0]              mode_field,
  output smf_pkg::smf_mode_t      mode,
  output smf_pkg::smf_status_t    status
);
  import smf_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic int_s1;
  logic int_s2;
  logic test_s1;
  logic test_s2;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_s1  <= 1'b0;
      int_s2  <= 1'b0;
      test_s1 <= 1'b1;
      test_s2 <= 1'b1;
    end else begin
      int_s1  <= interrupt_pin_in;
      int_s2  <= int_s1;
      test_s1 <= test_pin;
      test_s2 <= test_s1;
    end
  end

  // ----------------------------------------
  // failure decision
  // ----------------------------------------
  logic [31:0] rd_cnt;
  logic [31:0] lw_cnt;
  logic [31:0] flt_cnt;
  logic        flt_level;
  logic        flt_stable;
  logic        lw_open;
  logic        wd_fail;
  logic        ov_crit;
  logic        fail_second;
  logic        go_fail_safe;
  logic        set_fail_out;
  smf_mode_t   next_mode;

  assign ov_crit = overvoltage && overvoltage_reset_enable;
  // watchdog failure, suppressed entirely in development mode
  assign wd_fail = !status.development_mode &&
                   (wd_fail_event ||
                    (lw_open && lw_cnt == 32'(LW_CYC - 1)));
  assign fail_second = status.wd_fail_count != 2'h0;
  // config 4 restarts on the first failure, fail-safe from the second
  assign go_fail_safe = (!status.config_pin_level && ov_crit) ||
                        (!status.config_pin_level && wd_fail &&
                         (status.failure_count_select ||
                          fail_second));
  assign set_fail_out = ov_crit ||
                        (wd_fail && (status.failure_count_select ||
                                     fail_second));

  // ----------------------------------------
  // overtemperature release
  // ----------------------------------------
  // fail-safe is left when overtemperature goes away, not merely because
  // it is absent; otherwise a watchdog fail-safe would never hold
  logic ot_prev;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ot_prev <= 1'b0;
    end else begin
      ot_prev <= overtemp;
    end
  end

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      SMF_INIT: begin
        if (spi_cmd_valid) begin
          next_mode = SMF_NORMAL;
        end
        if (go_fail_safe) begin
          next_mode = SMF_FAIL_SAFE;
        end else if (wd_fail || undervoltage || ov_crit) begin
          next_mode = SMF_RESTART;
        end
      end
      SMF_NORMAL, SMF_STOP: begin
        if (spi_mode_write) begin
          if (spi_mode_value == SMF_REQ_NORMAL) begin
            next_mode = SMF_NORMAL;
          end else if (spi_mode_value == SMF_REQ_STOP) begin
            next_mode = SMF_STOP;
          end else if (spi_mode_value == SMF_REQ_SLEEP) begin
            // stop cannot go straight to sleep; it restarts instead
            next_mode = (mode == SMF_STOP) ? SMF_RESTART : SMF_SLEEP;
          end else if (spi_mode_value == SMF_REQ_RESET) begin
            next_mode = SMF_INIT;
          end
        end
        if (go_fail_safe) begin
          next_mode = SMF_FAIL_SAFE;
        end else if (wd_fail || undervoltage || ov_crit) begin
          next_mode = SMF_RESTART;
        end
      end
      SMF_SLEEP: begin
        if (wake_event) begin
          next_mode = SMF_RESTART;
        end
      end
      SMF_RESTART: begin
        if (go_fail_safe) begin
          next_mode = SMF_FAIL_SAFE;
        end else if (!undervoltage && !ov_crit &&
                     rd_cnt == 32'(RD_CYC - 1)) begin
          next_mode = SMF_NORMAL;
        end
      end
      SMF_FAIL_SAFE: begin
        // only a wake or a cleared overtemperature ends fail-safe
        if (wake_event || (ot_prev && !overtemp)) begin
          next_mode = SMF_RESTART;
        end
      end
      default: next_mode = SMF_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode <= SMF_INIT;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------
  // reset delay and reset output
  // ----------------------------------------
  // the delay restarts whenever a failure is still present
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_cnt <= '0;
    end else if (mode != SMF_RESTART || undervoltage || ov_crit) begin
      rd_cnt <= '0;
    end else if (rd_cnt != 32'(RD_CYC - 1)) begin
      rd_cnt <= rd_cnt + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reset_output <= 1'b0;
    end else begin
      reset_output <= (next_mode != SMF_RESTART) &&
                      (next_mode != SMF_FAIL_SAFE) &&
                      (next_mode != SMF_SLEEP);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_regulator_en <= 1'b1;
    end else begin
      main_regulator_en <= (next_mode != SMF_SLEEP) &&
                           (next_mode != SMF_FAIL_SAFE);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_field <= SMF_FIELD_RST;
    end else if (next_mode == SMF_RESTART) begin
      mode_field <= SMF_FIELD_RST;
    end else if (mode == SMF_NORMAL && next_mode != SMF_NORMAL) begin
      mode_field <= 3'(next_mode);
    end else if (next_mode == SMF_NORMAL || next_mode == SMF_STOP) begin
      mode_field <= (next_mode == SMF_NORMAL) ? SMF_REQ_NORMAL
                                              : SMF_REQ_STOP;
    end
  end

  // ----------------------------------------
  // watchdog long open window
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lw_open <= 1'b1;
      lw_cnt  <= '0;
    end else if (wd_trigger || wd_fail || status.development_mode) begin
      lw_open <= 1'b0;
      lw_cnt  <= '0;
    end else if (next_mode == SMF_INIT && mode != SMF_INIT) begin
      lw_open <= 1'b1;
      lw_cnt  <= '0;
    end else if (lw_open) begin
      lw_cnt  <= lw_cnt + 32'd1;
    end
  end

  // ----------------------------------------
  // configuration sampling on interrupt pin
  // ----------------------------------------
  logic sampling;
  logic ro_prev;
  assign sampling = !reset_output && status.power_on_reset_flag &&
                    (mode == SMF_INIT || mode == SMF_RESTART);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_pin_pd_oe_n <= 1'b1;
    end else begin
      interrupt_pin_pd_oe_n <= !sampling;
    end
  end

  // filter runs only while sampling: level counts as stable once held for the filter time
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flt_cnt    <= '0;
      flt_level  <= 1'b0;
      flt_stable <= 1'b0;
    end else if (!sampling || int_s2 != flt_level) begin
      flt_cnt    <= '0;
      flt_level  <= int_s2;
      flt_stable <= 1'b0;
    end else if (flt_cnt != 32'(CFG_CYC - 1)) begin
      flt_cnt    <= flt_cnt + 32'd1;
    end else begin
      flt_stable <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ro_prev <= 1'b0;
    end else begin
      ro_prev <= reset_output;
    end
  end

  // ----------------------------------------
  // status and failure bookkeeping
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= SMF_STATUS_RST;
      status.power_on_reset_flag <= 1'b1;
    end else begin
      status.failure_count_select <= failure_count_select;
      if (reset_output && !ro_prev && status.power_on_reset_flag) begin
        // pull-up reads one; no stable level falls back to zero
        status.config_pin_level <= flt_stable && flt_level;
      end
      if (power_on_flag_clear) begin
        status.power_on_reset_flag <= 1'b0;
      end
      if (mode == SMF_INIT) begin
        status.development_mode <= !test_s2;
      end
      if (overvoltage) begin
        status.overvoltage_flag <= 1'b1;
      end
      if (wd_fail && status.wd_fail_count != 2'h3) begin
        status.wd_fail_count <= status.wd_fail_count + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fail_output <= 1'b0;
    end else if (set_fail_out) begin
      fail_output <= 1'b1;
    end
  end
endmodule : smf_mode_fail_config
`default_nettype wire

// *** sim/smf_host_model.sv ***
`default_nettype none
module smf_host_model (
  input  wire logic clk,
  input  wire logic pull_up,
  input  wire logic noisy,
  input  wire logic pd_oe_n,
  output var  logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // interrupt pin
  // ----------------
  logic flip = 1'h0;
  // an undriven pin wanders so the simulator cannot pick a level for it
  always @(posedge clk) flip <= !flip;
  always_comb begin
    if (noisy) pin = flip;
    else if (pull_up) pin = 1'h1;
    else if (!pd_oe_n) pin = 1'h0;
    else pin = flip;
  end
endmodule : smf_host_model
`default_nettype wire

// *** sim/smf_mode_fail_config_sva.sv ***
`default_nettype none
module smf_mode_fail_config_sva (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 spi_cmd_valid,
  input wire logic                 wd_fail_event,
  input wire logic                 undervoltage,
  input wire logic                 overvoltage,
  input wire logic                 overvoltage_reset_enable,
  input wire logic                 overtemp,
  input wire logic                 wake_event,
  input wire logic                 interrupt_pin_pd_oe_n,
  input wire logic                 reset_output,
  input wire logic                 fail_output,
  input wire logic                 main_regulator_en,
  input wire logic [2:0]           mode_field,
  input wire smf_pkg::smf_mode_t   mode,
  input wire smf_pkg::smf_status_t status
);
  timeunit 1ns;
  timeprecision 1ns;
  import smf_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------
  // mode relations
  // ----------------
  sequence s_wd_fail;
    wd_fail_event && !status.development_mode && mode == SMF_NORMAL;
  endsequence
  property p_restart;
    mode == SMF_RESTART |-> !reset_output && mode_field == SMF_FIELD_RST;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_reg;
    mode inside {SMF_SLEEP, SMF_FAIL_SAFE} |-> !main_regulator_en;
  endproperty
  a_reg: assert property (p_reg) else $error("regulator on");
  property p_fs_hold;
    mode == SMF_FAIL_SAFE && !wake_event && !overtemp && !$past(overtemp)
      |=> mode == SMF_FAIL_SAFE;
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fail-safe left");
  property p_exit;
    $past(mode) == SMF_RESTART && mode != SMF_RESTART |-> mode == SMF_NORMAL;
  endproperty
  a_exit: assert property (p_exit) else $error("restart exit");
  property p_init;
    mode == SMF_INIT && spi_cmd_valid && !wd_fail_event && !undervoltage
      |=> mode == SMF_NORMAL;
  endproperty
  a_init: assert property (p_init) else $error("init exit");
  property p_cfg1;
    s_wd_fail ##0 status.config_pin_level |=> mode == SMF_RESTART
      && (fail_output || !status.failure_count_select);
  endproperty
  a_cfg1: assert property (p_cfg1) else $error("pull-up failure");
  property p_cfg2;
    s_wd_fail ##0 !status.config_pin_level && status.failure_count_select
      |=> mode == SMF_FAIL_SAFE && fail_output;
  endproperty
  a_cfg2: assert property (p_cfg2) else $error("fail-safe entry");
  property p_ov;
    overvoltage && overvoltage_reset_enable && mode == SMF_NORMAL
      |=> fail_output && status.overvoltage_flag;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage");
  property p_ov_off;
    overvoltage && !overvoltage_reset_enable && !wd_fail_event
      |=> status.overvoltage_flag && $stable(fail_output);
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("ov flag only");
  // ----------------
  // configuration
  // ----------------
  property p_pd;
    $past(reset_n) && ($past(mode) inside {SMF_INIT, SMF_RESTART}) &&
      !$past(reset_output) && $past(status.power_on_reset_flag)
      |-> !interrupt_pin_pd_oe_n;
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down off");
  property p_hold;
    $changed(status.config_pin_level)
      |-> !$past(reset_output) || !$past(reset_output, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
endmodule : smf_mode_fail_config_sva
bind smf_mode_fail_config smf_mode_fail_config_sva u_sva (.*);
`default_nettype wire

// *** sim/smf_mode_fail_config_bench.sv ***
`default_nettype none
module smf_mode_fail_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import smf_pkg::*;
  localparam int          RD    = 20;
  localparam int          LW    = 200;
  localparam int          CF    = 4;
  localparam logic [10:0] E_SPI = 11'h060;
  localparam logic [10:0] E_WD  = 11'h010;
  localparam logic [10:0] E_WK  = 11'h008;
  localparam logic [10:0] E_UV  = 11'h004;
  localparam logic [10:0] E_OV  = 11'h002;
  localparam logic [10:0] E_CLR = 11'h001;
  logic        clk, reset_n, spi_cmd_valid, spi_mode_write, wd_trigger;
  logic        wd_fail_event, undervoltage, overvoltage, overtemp;
  logic        wake_event, overvoltage_reset_enable, failure_count_select;
  logic        power_on_flag_clear, test_pin, interrupt_pin_in, pull_up;
  logic        noisy, interrupt_pin_pd_oe_n, reset_output, fail_output;
  logic        main_regulator_en;
  logic [2:0]  spi_mode_value, mode_field;
  logic [10:0] ev;
  smf_mode_t   mode;
  smf_status_t status;
  int          fails, samples_checked, cyc;
  assign {spi_mode_write, spi_mode_value, spi_cmd_valid, wd_trigger,
          wd_fail_event, wake_event, undervoltage, overvoltage,
          power_on_flag_clear} = ev;
  smf_mode_fail_config #(.RD_CYC(RD), .LW_CYC(LW), .CFG_CYC(CF)) dut (.*);
  smf_host_model host (.clk(clk), .pull_up(pull_up), .noisy(noisy),
    .pd_oe_n(interrupt_pin_pd_oe_n), .pin(interrupt_pin_in));
  always #10 clk = !clk;
  // ----------------
  // access tasks
  // ----------------
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic boot(input logic [2:0] pins);
    @(posedge clk);
    {pull_up, noisy, test_pin, reset_n} <= {pins, 1'h0};
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    // stay in init long enough for the test pin to pass its synchroniser
    repeat (3) @(posedge clk);
  endtask : boot
  // events are one-cycle pulses; the spi frame also refreshes the watchdog
  task automatic hit(input logic [10:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 11'h000;
  endtask : hit
  task automatic wr(input logic [2:0] v);
    hit({1'h1, v, E_SPI[6:0]});
  endtask : wr
  task automatic wt(input smf_mode_t m, input int n);
    #1;
    for (int i = 0; i < n && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk(mode, m);
  endtask : wt
  task automatic relatch(input logic c);
    hit(E_UV);
    wt(SMF_RESTART, 4);
    chk({reset_output, mode_field} == 4'h0, 3'h1);
    wt(SMF_NORMAL, RD + CF + 10);
    // the level is latched one edge after the reset output rises
    @(posedge clk);
    #1;
    chk(3'(status.config_pin_level), 3'(c));
  endtask : relatch
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    {clk, ev, overtemp, overvoltage_reset_enable} = '0;
    {reset_n, pull_up, noisy, test_pin, failure_count_select} = 5'h3;
    boot(3'h5);
    hit(E_SPI);
    wt(SMF_NORMAL, 4);
    wr(SMF_REQ_RESET);
    wt(SMF_INIT, 4);
    hit(E_SPI);
    wt(SMF_NORMAL, 4);
    relatch(1'h1);
    hit(E_WD);
    wt(SMF_RESTART, 4);
    chk(3'(fail_output), 3'h1);
    $display("test 1 done");
    @(posedge clk) failure_count_select <= 1'h0;
    boot(3'h1);
    hit(E_SPI);
    wt(SMF_NORMAL, 4);
    relatch(1'h0);
    chk(3'(status.failure_count_select), 3'h0);
    wr(SMF_REQ_STOP);
    wt(SMF_STOP, 4);
    chk(3'(main_regulator_en), 3'h1);
    wr(SMF_REQ_NORMAL);
    wt(SMF_NORMAL, 4);
    wr(SMF_REQ_SLEEP);
    wt(SMF_SLEEP, 4);
    chk(3'(main_regulator_en), 3'h0);
    hit(E_WK);
    wt(SMF_RESTART, 4);
    wt(SMF_NORMAL, RD + CF + 10);
    hit(E_WD);
    wt(SMF_RESTART, 4);
    chk(3'(fail_output), 3'h0);
    wt(SMF_NORMAL, RD + CF + 10);
    hit(E_WD);
    wt(SMF_FAIL_SAFE, 4);
    chk({fail_output, main_regulator_en}, 3'h2);
    hit(E_WK);
    wt(SMF_RESTART, 4);
    $display("test 2 done");
    boot(3'h1);
    hit(E_SPI);
    wt(SMF_NORMAL, 4);
    relatch(1'h0);
    hit(E_OV);
    wt(SMF_NORMAL, 2);
    chk({status.overvoltage_flag, fail_output}, 3'h2);
    @(posedge clk) overvoltage_reset_enable <= 1'h1;
    hit(E_OV);
    wt(SMF_FAIL_SAFE, 4);
    chk({status.overvoltage_flag, fail_output}, 3'h3);
    repeat (4) @(posedge clk);
    wt(SMF_FAIL_SAFE, 1);
    @(posedge clk) overtemp <= 1'h1;
    @(posedge clk) overtemp <= 1'h0;
    wt(SMF_RESTART, 4);
    @(posedge clk) overvoltage_reset_enable <= 1'h0;
    $display("test 3 done");
    boot(3'h4);
    hit(E_SPI);
    wt(SMF_NORMAL, 4);
    chk(3'(status.development_mode), 3'h1);
    repeat (LW + 20) @(posedge clk);
    wt(SMF_NORMAL, 1);
    relatch(1'h1);
    @(posedge clk) pull_up <= 1'h0;
    hit(E_CLR);
    relatch(1'h1);
    $display("test 4 done");
    boot(3'h3);
    wt(SMF_RESTART, LW + 20);
    wt(SMF_NORMAL, RD + CF + 10);
    chk(3'(status.config_pin_level), 3'h0);
    @(posedge clk) failure_count_select <= 1'h1;
    hit(E_WD);
    wt(SMF_FAIL_SAFE, 4);
    $display("test 5 done");
    end_sim();
  end
endmodule : smf_mode_fail_config_bench
`default_nettype wire
